// ### rtl/ddc_regs.vh
`ifndef DDC_REGS_VH
`define DDC_REGS_VH

// serial word framing
`define DDC_WORD_BITS 32
`define DDC_CNT_W 5
`define DDC_CNT_LAST 5'h1F
`define DDC_CNT_ZERO 5'h00
`define DDC_CMD_HI 27
`define DDC_CMD_LO 24
`define DDC_ADDR_HI 23
`define DDC_ADDR_LO 20
`define DDC_DATA_HI 19
`define DDC_DATA_LO 4

// command codes
`define DDC_CMD_WRITE 4'h0
`define DDC_CMD_UPDATE 4'h1
`define DDC_CMD_WRITE_UPD_ALL 4'h2
`define DDC_CMD_WRITE_UPD 4'h3
`define DDC_CMD_PWRDN 4'h4
`define DDC_CMD_CLR_CODE 4'h5
`define DDC_CMD_LOAD_OVR 4'h6
`define DDC_CMD_SW_RESET 4'h7
`define DDC_CMD_CHAIN 4'h8

// channel address codes
`define DDC_ADDR_A 4'h0
`define DDC_ADDR_B 4'h3
`define DDC_ADDR_BOTH 4'hF

// field positions
`define DDC_PWRDN_MODE_HI 9
`define DDC_PWRDN_MODE_LO 8
`define DDC_PDSEL_A 0
`define DDC_PDSEL_B 3
`define DDC_CLR_CODE_HI 1
`define DDC_CLR_CODE_LO 0
`define DDC_CHAIN_BIT 1
`define DDC_OVR_A 0
`define DDC_OVR_B 3

// power-down modes
`define DDC_PD_NORMAL 2'h0
`define DDC_PD_1K 2'h1
`define DDC_PD_100K 2'h2
`define DDC_PD_TRISTATE 2'h3

// clear code selections and codes
`define DDC_CLR_ZERO 2'h0
`define DDC_CLR_MID 2'h1
`define DDC_CLR_FULL 2'h2
`define DDC_CLR_NOP 2'h3
`define DDC_CODE_ZERO 16'h0000
`define DDC_CODE_MID 16'h8000
`define DDC_CODE_FULL 16'hFFFF

// reset values
`define DDC_RST_CLR_CODE 2'h0
`define DDC_RST_LOAD_OVR 4'h0
`define DDC_RST_CHAIN 1'b0
`define DDC_RST_PD 2'h0

// pin synchroniser: {reset_level_sel, async_clear_n, output_load_n, din, sync_n, sclk}
`define DDC_PIN_W 6
`define DDC_PIN_RST 6'h1B

`endif

// ### rtl/ddc_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for a group of pins
module ddc_sync #(
	parameter W = 6,
	parameter [W-1:0] RST = {W{1'b0}}
)(
	input wire i_clk,
	input wire i_reset,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);

genvar g;
generate
for (g = 0; g < W; g = g + 1)
begin : bit_g
	reg meta;
	reg stable;
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			meta <= RST[g];
			stable <= RST[g];
		end
		else
		begin
			meta <= i_async[g];
			stable <= meta;
		end
	end
	assign o_sync[g] = stable;
end
endgenerate

endmodule

// ### rtl/ddc_core.v
`timescale 1ns/1ps
`include "ddc_regs.vh"

//
// Overview of operation
// - command 1000 sets chain mode from bit 1
// - power-up code zero or midscale from pin
// - hold power-up code until first valid write
// - command 0111 returns to power-up code
// - command 0100 takes mode from bits 9:8
// - modes: normal, 1k, 100k, three-state
// - powered-down channel keeps DAC register unchanged except on clear
// - power-down applies to selected channels only
// - power-up loads input or keeps DAC value
// - clear falling edge loads all with code unless clear code is 11
// - command 0101 sets clear code from bits 1:0
// - clear code resets to zero code
// - clear mode ends at next write's 32nd edge
// - clear during a write aborts that write
// - load pin low updates at 32nd edge
// - load pin high defers; falling edge copies
// - command 0010 writes then updates all channels
// - override bit makes channel see load low
// - word: 4 spare, command, address, data, MSB first
// - address 0000 A, 0011 B, 1111 both
// - early frame end discards the partial word
module ddc_core (
	input wire i_clk,
	input wire i_reset,
	input wire i_sclk,
	input wire i_sync_n,
	input wire i_din,
	input wire i_output_load_n,
	input wire i_async_clear_n,
	input wire i_reset_level_sel,
	output reg o_serial_out,
	output wire [15:0] o_dac_a,
	output wire [15:0] o_dac_b,
	output wire [15:0] o_input_a,
	output wire [15:0] o_input_b,
	output wire [1:0] o_pwrdn_a,
	output wire [1:0] o_pwrdn_b,
	output wire o_chain_mode_on,
	output wire [1:0] o_clear_code,
	output wire [3:0] o_load_override,
	output wire o_clear_mode,
	output wire o_por_hold,
	output reg o_word_done,
	output reg o_frame_discard
);

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_SHIFT = 4'h2;
localparam [3:0] ST_HOLD = 4'h4;
localparam [3:0] ST_ABORT = 4'h8;

// one bit per channel: bit 0 channel A, bit 1 channel B; reserved gives none
function [1:0] addr_mask;
	input [3:0] addr;
	begin
		case (addr)
			`DDC_ADDR_A: addr_mask = 2'h1;
			`DDC_ADDR_B: addr_mask = 2'h2;
			`DDC_ADDR_BOTH: addr_mask = 2'h3;
			default: addr_mask = 2'h0;
		endcase
	end
endfunction

function [15:0] clear_value;
	input [1:0] sel;
	begin
		case (sel)
			`DDC_CLR_MID: clear_value = `DDC_CODE_MID;
			`DDC_CLR_FULL: clear_value = `DDC_CODE_FULL;
			default: clear_value = `DDC_CODE_ZERO;
		endcase
	end
endfunction

function cmd_writes_input;
	input [3:0] cmd;
	begin
		cmd_writes_input = (cmd == `DDC_CMD_WRITE) || (cmd == `DDC_CMD_WRITE_UPD_ALL) ||
			(cmd == `DDC_CMD_WRITE_UPD);
	end
endfunction

// pin synchronisation and edge detection
wire [`DDC_PIN_W-1:0] pins_s;
reg [`DDC_PIN_W-1:0] pins_d;

ddc_sync #(
	.W(`DDC_PIN_W),
	.RST(`DDC_PIN_RST)
) u_sync (
	.i_clk(i_clk),
	.i_reset(i_reset),
	.i_async({i_reset_level_sel, i_async_clear_n, i_output_load_n, i_din, i_sync_n, i_sclk}),
	.o_sync(pins_s)
);

always @(posedge i_clk or posedge i_reset)
begin
	if (i_reset)
		pins_d <= `DDC_PIN_RST;
	else
		pins_d <= pins_s;
end

wire sclk_s = pins_s[0];
wire sync_n_s = pins_s[1];
wire din_s = pins_s[2];
wire load_n_s = pins_s[3];
wire level_sel_s = pins_s[5];
wire sclk_fall = pins_d[0] & ~sclk_s;
wire sclk_rise = ~pins_d[0] & sclk_s;
wire sync_fall = pins_d[1] & ~sync_n_s;
wire sync_rise = ~pins_d[1] & sync_n_s;
wire load_fall = pins_d[3] & ~load_n_s;
wire clr_fall = pins_d[4] & ~pins_s[4];

// settings
reg [1:0] clear_code_select;
reg [3:0] load_override;
reg chain_mode_enable;
reg por_pend;
reg clear_mode;

// frame engine
reg [3:0] state;
reg [3:0] next_state;
reg [`DDC_WORD_BITS-1:0] shift;
reg [`DDC_CNT_W-1:0] cnt;
reg seen_word;
reg exec_req;
reg next_exec_req;
reg discard;

// a clear edge cancels a word that is about to execute
wire exec = exec_req & ~clr_fall;
wire [3:0] cmd = shift[`DDC_CMD_HI:`DDC_CMD_LO];
wire [3:0] addr = shift[`DDC_ADDR_HI:`DDC_ADDR_LO];
wire [15:0] data = shift[`DDC_DATA_HI:`DDC_DATA_LO];
wire [1:0] chmask = addr_mask(addr);
wire [1:0] pd_mode = shift[`DDC_PWRDN_MODE_HI:`DDC_PWRDN_MODE_LO];
wire sw_reset = exec && (cmd == `DDC_CMD_SW_RESET);
wire clr_load = clr_fall && (clear_code_select != `DDC_CLR_NOP);
wire [15:0] clr_val = clear_value(clear_code_select);
wire [15:0] por_code = level_sel_s ? `DDC_CODE_MID : `DDC_CODE_ZERO;

always @*
begin
	next_state = state;
	next_exec_req = 1'b0;
	discard = 1'b0;
	case (state)
		ST_IDLE:
		begin
			if (sync_fall)
				next_state = ST_SHIFT;
		end
		ST_SHIFT:
		begin
			if (clr_fall)
				next_state = ST_ABORT;
			else if (sync_rise)
			begin
				next_state = ST_IDLE;
				// chain mode executes the last word once a whole multiple of 32 bits arrived
				if (chain_mode_enable && seen_word && (cnt == `DDC_CNT_ZERO))
					next_exec_req = 1'b1;
				else if (!(chain_mode_enable && seen_word))
					discard = 1'b1;
				else
					discard = 1'b1;
			end
			else if (sclk_fall && (cnt == `DDC_CNT_LAST) && !chain_mode_enable)
			begin
				next_exec_req = 1'b1;
				next_state = ST_HOLD;
			end
		end
		ST_HOLD:
		begin
			if (sync_rise)
				next_state = ST_IDLE;
		end
		ST_ABORT:
		begin
			if (sync_rise)
				next_state = ST_IDLE;
		end
		default:
			next_state = ST_IDLE;
	endcase
end

always @(posedge i_clk or posedge i_reset)
begin
	if (i_reset)
	begin
		state <= ST_IDLE;
		shift <= {`DDC_WORD_BITS{1'b0}};
		cnt <= `DDC_CNT_ZERO;
		seen_word <= 1'b0;
		exec_req <= 1'b0;
		o_serial_out <= 1'b0;
		o_word_done <= 1'b0;
		o_frame_discard <= 1'b0;
	end
	else
	begin
		state <= next_state;
		exec_req <= next_exec_req;
		o_word_done <= exec;
		o_frame_discard <= discard | (clr_fall & (state == ST_SHIFT));
		if (state == ST_IDLE && sync_fall)
		begin
			cnt <= `DDC_CNT_ZERO;
			seen_word <= 1'b0;
		end
		else if (state == ST_SHIFT && sclk_fall && !clr_fall && !sync_rise)
		begin
			shift <= {shift[`DDC_WORD_BITS-2:0], din_s};
			cnt <= cnt + 5'h01;
			if (cnt == `DDC_CNT_LAST)
				seen_word <= 1'b1;
		end
		// bits beyond the word ripple out on rising edges in chain mode
		if (!chain_mode_enable)
			o_serial_out <= 1'b0;
		else if (state == ST_SHIFT && sclk_rise)
			o_serial_out <= shift[`DDC_WORD_BITS-1];
	end
end

// settings registers and mode flags
always @(posedge i_clk or posedge i_reset)
begin
	if (i_reset)
	begin
		clear_code_select <= `DDC_RST_CLR_CODE;
		load_override <= `DDC_RST_LOAD_OVR;
		chain_mode_enable <= `DDC_RST_CHAIN;
		por_pend <= 1'b1;
		clear_mode <= 1'b0;
	end
	else
	begin
		if (sw_reset)
		begin
			clear_code_select <= `DDC_RST_CLR_CODE;
			load_override <= `DDC_RST_LOAD_OVR;
			chain_mode_enable <= `DDC_RST_CHAIN;
			por_pend <= 1'b1;
		end
		else if (exec)
		begin
			por_pend <= 1'b0;
			if (cmd == `DDC_CMD_CLR_CODE)
				clear_code_select <= shift[`DDC_CLR_CODE_HI:`DDC_CLR_CODE_LO];
			if (cmd == `DDC_CMD_LOAD_OVR)
			begin
				load_override <= 4'h0;
				load_override[`DDC_OVR_A] <= shift[`DDC_OVR_A];
				load_override[`DDC_OVR_B] <= shift[`DDC_OVR_B];
			end
			if (cmd == `DDC_CMD_CHAIN)
				chain_mode_enable <= shift[`DDC_CHAIN_BIT];
		end
		// set wins over the clear at the 32nd edge
		if (clr_fall)
			clear_mode <= 1'b1;
		else if (exec)
			clear_mode <= 1'b0;
	end
end

// per-channel input register, DAC register and power-down mode
genvar ch;
generate
for (ch = 0; ch < 2; ch = ch + 1)
begin : ch_g
	reg [15:0] in_reg;
	reg [15:0] dac;
	reg [1:0] pd;
	wire sel;
	wire ov;
	wire pdsel;
	wire eff_sync;
	wire in_wr;
	wire pd_cmd;
	wire power_up;
	wire norm_load;
	wire dac_load;
	wire [15:0] next_in;

	assign sel = chmask[ch];
	assign ov = (ch == 0) ? load_override[`DDC_OVR_A] : load_override[`DDC_OVR_B];
	assign pdsel = (ch == 0) ? shift[`DDC_PDSEL_A] : shift[`DDC_PDSEL_B];
	assign eff_sync = ~load_n_s | ov;
	assign in_wr = exec & sel & cmd_writes_input(cmd);
	assign pd_cmd = exec && (cmd == `DDC_CMD_PWRDN) && pdsel;
	assign power_up = pd_cmd && (pd_mode == `DDC_PD_NORMAL) && eff_sync;
	assign norm_load = (exec & sel & ((cmd == `DDC_CMD_UPDATE) | (cmd == `DDC_CMD_WRITE_UPD))) |
		(exec & (cmd == `DDC_CMD_WRITE_UPD_ALL)) |
		(exec & sel & (cmd == `DDC_CMD_WRITE) & eff_sync) |
		load_fall;
	assign dac_load = (norm_load & (pd == `DDC_PD_NORMAL)) | power_up;
	assign next_in = in_wr ? data : in_reg;

	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			in_reg <= `DDC_CODE_ZERO;
			dac <= `DDC_CODE_ZERO;
			pd <= `DDC_RST_PD;
		end
		else if (clr_load)
		begin
			in_reg <= clr_val;
			dac <= clr_val;
		end
		else if (por_pend && !exec)
		begin
			in_reg <= por_code;
			dac <= por_code;
		end
		else
		begin
			in_reg <= next_in;
			if (dac_load)
				dac <= next_in;
			if (sw_reset)
				pd <= `DDC_RST_PD;
			else if (pd_cmd)
				pd <= pd_mode;
		end
	end
end
endgenerate

assign o_dac_a = ch_g[0].dac;
assign o_dac_b = ch_g[1].dac;
assign o_input_a = ch_g[0].in_reg;
assign o_input_b = ch_g[1].in_reg;
assign o_pwrdn_a = ch_g[0].pd;
assign o_pwrdn_b = ch_g[1].pd;
assign o_chain_mode_on = chain_mode_enable;
assign o_clear_code = clear_code_select;
assign o_load_override = load_override;
assign o_clear_mode = clear_mode;
assign o_por_hold = por_pend;

endmodule

// ### tb/ddc_core_sva.sv
`timescale 1ns/1ps
module ddc_core_chk (
	input wire i_clk,
	input wire i_reset,
	input wire i_async_clear_n,
	input wire o_serial_out,
	input wire [15:0] o_dac_a,
	input wire [15:0] o_dac_b,
	input wire [1:0] o_pwrdn_a,
	input wire o_chain_mode_on,
	input wire [1:0] o_clear_code,
	input wire [3:0] o_load_override,
	input wire o_clear_mode,
	input wire o_por_hold,
	input wire o_word_done,
	input wire o_frame_discard
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire [15:0] clr_val = o_clear_code == 2'h0 ? 16'h0000 : o_clear_code == 2'h1 ? 16'h8000 : 16'hffff;
	clr_enter_a: assert property ($fell(i_async_clear_n) |-> ##[1:6] o_clear_mode)
		else $error("clear edge missed");
	clr_value_a: assert property ($rose(o_clear_mode) && o_clear_code != 2'h3 |->
		o_dac_a == clr_val && o_dac_b == clr_val) else $error("wrong clear code loaded");
	serial_quiet_a: assert property ((!o_chain_mode_on) [*3] |-> !o_serial_out)
		else $error("serial out active outside chain mode");
	pd_keep_a: assert property (o_pwrdn_a != 2'h0 && $stable(o_pwrdn_a) && !o_clear_mode && !o_por_hold
		|-> $stable(o_dac_a)) else $error("powered-down register changed");
	done_exit_a: assert property (o_word_done |-> !o_clear_mode)
		else $error("clear mode kept after word");
	one_result_a: assert property (!(o_word_done && o_frame_discard))
		else $error("word both done and discarded");
	ovr_bits_a: assert property (o_load_override[2:1] == 2'h0)
		else $error("unused override bits set");
	por_code_a: assert property (o_por_hold && $past(o_por_hold) && !o_clear_mode |->
		o_dac_a == o_dac_b && (o_dac_a == 16'h0000 || o_dac_a == 16'h8000)) else $error("bad power-up code");
endmodule

bind ddc_core ddc_core_chk ddc_core_chk_i (.i_clk, .i_reset, .i_async_clear_n, .o_serial_out, .o_dac_a,
	.o_dac_b, .o_pwrdn_a, .o_chain_mode_on, .o_clear_code, .o_load_override, .o_clear_mode, .o_por_hold,
	.o_word_done, .o_frame_discard);

// ### tb/ddc_host.sv
`timescale 1ns/1ps
module ddc_host (
	input wire i_clk,
	output reg o_sclk,
	output reg o_sync_n,
	output reg o_din
);
	integer k;
	initial
	begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_din = 1'b0;
	end
	task automatic tick(input integer n);
	begin
		repeat (n) @(posedge i_clk);
	end
	endtask
	// n below 32 interrupts the frame; sclk rests high between frames
	task send(input [31:0] w, input integer n);
	begin
		o_sync_n <= 1'b0;
		for (k = 0; k < n; k = k + 1)
		begin
			o_din <= w[31-k];
			tick(4);
			o_sclk <= 1'b0;
			tick(4);
			o_sclk <= 1'b1;
		end
		tick(4);
		o_sync_n <= 1'b1;
		o_din <= ~o_din;
		tick(12);
	end
	endtask
endmodule

// ### tb/tb_ddc_core.sv
`timescale 1ns/1ps
module tb_ddc_core;
	reg i_clk = 1'b0;
	reg i_reset = 1'b1;
	reg load_n = 1'b1;
	reg clear_n = 1'b1;
	reg level_sel = 1'b0;
	wire sclk, sync_n, din, ser, chain_on, clr_mode, por_hold, done, discard;
	wire [15:0] dac_a, dac_b, in_a, in_b;
	wire [1:0] pd_a, pd_b, clr_code;
	wire [3:0] ovr;
	integer fail_count = 0;
	integer checks_done = 0;
	integer m;
	integer done_cnt = 0;
	integer discard_cnt = 0;
	// pulse outputs stand one cycle, so they are counted as they occur
	always @(posedge i_clk)
	begin
		if (done === 1'b1)
			done_cnt <= done_cnt + 1;
		if (discard === 1'b1)
			discard_cnt <= discard_cnt + 1;
	end
	always #12.5 i_clk = ~i_clk;
	ddc_host ddc_host_i (.i_clk(i_clk), .o_sclk(sclk), .o_sync_n(sync_n), .o_din(din));
	ddc_core ddc_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_sync_n(sync_n), .i_din(din),
		.i_output_load_n(load_n), .i_async_clear_n(clear_n), .i_reset_level_sel(level_sel),
		.o_serial_out(ser), .o_dac_a(dac_a), .o_dac_b(dac_b), .o_input_a(in_a), .o_input_b(in_b),
		.o_pwrdn_a(pd_a), .o_pwrdn_b(pd_b), .o_chain_mode_on(chain_on), .o_clear_code(clr_code),
		.o_load_override(ovr), .o_clear_mode(clr_mode), .o_por_hold(por_hold), .o_word_done(done),
		.o_frame_discard(discard));
	task chk(input [15:0] got, input [15:0] exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task send(input [31:0] w);
	begin
		ddc_host_i.send(w, 32);
	end
	endtask
	task pulse_clear;
	begin
		clear_n <= 1'b0;
		ddc_host_i.tick(8);
		clear_n <= 1'b1;
		ddc_host_i.tick(8);
	end
	endtask
	task pulse_load;
	begin
		load_n <= 1'b0;
		ddc_host_i.tick(8);
		load_n <= 1'b1;
		ddc_host_i.tick(8);
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	initial
	begin
		#1000000;
		fail_count = fail_count + 1;
		complete_run;
	end
	initial
	begin
		ddc_host_i.tick(6);
		i_reset <= 1'b0;
		ddc_host_i.tick(4);
		chk(dac_a, 16'h0000);
		chk(clr_code, 2'h0);
		level_sel <= 1'b1;
		ddc_host_i.tick(6);
		chk(dac_b, 16'h8000);
		send(32'h0301_2340);
		chk(dac_a, 16'h1234);
		chk(done_cnt, 16'h0001);
		chk(ser, 16'h0000);
		chk(por_hold, 1'b0);
		chk(dac_b, 16'h8000);
		ddc_host_i.send(32'h0303_5550, 20);
		chk(dac_b, 16'h8000);
		chk(discard_cnt, 16'h0001);
		send(32'h0311_1110);
		chk(dac_b, 16'h8000);
		for (m = 0; m < 4; m = m + 1)
		begin
			send({16'h0400, 6'h00, m[1:0], 8'h08});
			chk(pd_b, m[1:0]);
			chk(pd_a, 2'h0);
		end
		send(32'h0400_0101);
		chk(pd_a, 2'h1);
		send(32'h0300_5550);
		chk(dac_a, 16'h1234);
		send(32'h0400_0009);
		chk(dac_a, 16'h1234);
		send(32'h00fa_aaa0);
		chk(dac_b, 16'h8000);
		chk(in_b, 16'haaaa);
		pulse_load;
		chk(dac_b, 16'haaaa);
		send(32'h0500_0002);
		chk(clr_code, 2'h2);
		pulse_clear;
		chk(dac_b, 16'hffff);
		fork
			send(32'h0300_1110);
			begin
				ddc_host_i.tick(100);
				pulse_clear;
			end
		join
		chk(in_a, 16'hffff);
		chk(discard_cnt, 16'h0002);
		chk(done_cnt, 16'h000b);
		send(32'h0600_0001);
		chk(ovr, 4'h1);
		chk(clr_mode, 1'b0);
		send(32'h0002_2220);
		chk(dac_a, 16'h2222);
		send(32'h0034_4440);
		send(32'h0200_5550);
		chk(dac_b, 16'h4444);
		send(32'h0800_0002);
		chk(chain_on, 1'b1);
		send(32'h8034_6660);
		chk(ser, 16'h0001);
		chk(in_b, 16'h4666);
		chk(dac_b, 16'h4444);
		pulse_load;
		chk(dac_b, 16'h4666);
		ddc_host_i.send(32'h8034_1110, 20);
		chk(discard_cnt, 16'h0003);
		chk(in_b, 16'h4666);
		send(32'h0700_0000);
		chk(dac_a, 16'h8000);
		chk({chain_on, ovr, clr_code}, 7'h00);
		send(32'h0500_0001);
		chk(clr_code, 16'h0001);
		i_reset <= 1'b1;
		ddc_host_i.tick(2);
		i_reset <= 1'b0;
		ddc_host_i.tick(4);
		chk(clr_code, 16'h0000);
		chk(dac_b, 16'h8000);
		chk(por_hold, 16'h0001);
		chk(pd_b, 16'h0000);
		complete_run;
	end
endmodule
